/* rtl/wdt_pkg.sv */
// shared constants and types for the watchdog timer monitor
package wdt_pkg;

    // ********************************************************
    // register map (byte addresses on the register bus)
    // ********************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;    // watchdog_control
    localparam logic [7:0] ADDR_CLKSEL   = 8'h04;    // interval select
    localparam logic [7:0] ADDR_TA       = 8'h08;    // timed_access_reg
    localparam logic [7:0] ADDR_IEN      = 8'h0C;    // irq enables
    localparam logic [7:0] ADDR_EVT_STAT = 8'h10;    // sticky events, write one to clear
    localparam logic [7:0] ADDR_EVT_MASK = 8'h14;    // event mask

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int BIT_RESTART    = 0;
    localparam int BIT_RST_EN     = 1;
    localparam int BIT_DOG_FLAG   = 2;
    localparam int BIT_IRQ_FLAG   = 3;
    localparam int BIT_SEL_LO     = 6;
    localparam int BIT_SEL_HI     = 7;
    localparam int BIT_TOUT_IEN   = 4;
    localparam int BIT_GLOBAL_IEN = 7;
    localparam int EVT_TOUT       = 0;
    localparam int EVT_DOGRST     = 1;

    // ********************************************************
    // reset values, keys, counts
    // ********************************************************
    localparam logic [1:0] SEL_RST      = 2'h0;
    localparam logic [7:0] TA_KEY1      = 8'hAA;
    localparam logic [7:0] TA_KEY2      = 8'h55;
    localparam int unsigned TOUT_SEL0_CLKS = 131072;
    localparam int unsigned TOUT_SEL1_CLKS = 1048576;
    localparam int unsigned TOUT_SEL2_CLKS = 8388608;
    localparam int unsigned TOUT_SEL3_CLKS = 67108864;
    localparam int unsigned POST_TOUT_CLKS = 512;
    localparam int unsigned MACHINE_CYCLE_CLKS = 4;
    localparam int unsigned RST_HOLD_CLKS  = 2 * MACHINE_CYCLE_CLKS;
    localparam int unsigned TA_OPEN_CLKS   = 4;
    localparam int CNT_W  = 26;
    localparam int POST_W = 10;
    localparam int HOLD_W = 4;
    localparam int TA_W   = 3;

    // ********************************************************
    // bus answers and watchdog states
    // ********************************************************
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_COUNT  = 3'b001,
        ST_GRACE  = 3'b010,
        ST_DOGRST = 3'b100
    } wd_state_t;

endpackage

/* rtl/ta_unlock.sv */
// timed-access unlock: key pair opens a short write window
module ta_unlock
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ta_wr,
    input  wire logic [7:0] ta_data,
    input  wire logic       prot_wr,
    output logic            unlock_open
);
    import wdt_pkg::*;

    typedef struct packed {
        logic            key1_seen;
        logic [TA_W-1:0] open_cnt;
    } ta_state_t;

    ta_state_t s_ff;
    ta_state_t nxt_s;

    // ********************************************************
    // key sequence and window countdown
    // ********************************************************
    always_comb
    begin
        nxt_s = s_ff;
        if (s_ff.open_cnt != '0)
        begin
            nxt_s.open_cnt = s_ff.open_cnt - 1'b1;
        end
        // one protected write per unlock, so a runaway loop cannot reuse it
        if (prot_wr)
        begin
            nxt_s.open_cnt = '0;
        end
        if (ta_wr)
        begin
            nxt_s.key1_seen = (ta_data == TA_KEY1);
            if (ta_data == TA_KEY2 && s_ff.key1_seen)
            begin
                nxt_s.open_cnt = TA_W'(TA_OPEN_CLKS);
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_ff <= '0;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign unlock_open = (s_ff.open_cnt != '0);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ta_key_open: assert property (ta_wr && ta_data == TA_KEY2 && s_ff.key1_seen |=> unlock_open &&
        s_ff.open_cnt == TA_W'(TA_OPEN_CLKS)) else $error("unlock window not opened by key pair");
    a_ta_window_end: assert property (s_ff.open_cnt == 1 && !ta_wr |=> !unlock_open)
        else $error("unlock window open too long");
    a_ta_single_use: assert property (prot_wr && !ta_wr |=> !unlock_open)
        else $error("unlock window reused after protected write");
endmodule

/* rtl/watchdog_timer_monitor.sv */
// watchdog timer monitor with axi4-lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module watchdog_timer_monitor
#(
    parameter int unsigned TOUT0 = wdt_pkg::TOUT_SEL0_CLKS,
    parameter int unsigned TOUT1 = wdt_pkg::TOUT_SEL1_CLKS,
    parameter int unsigned TOUT2 = wdt_pkg::TOUT_SEL2_CLKS,
    parameter int unsigned TOUT3 = wdt_pkg::TOUT_SEL3_CLKS
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        power_fail_rst,
    output logic             irq,
    output logic             wdt_irq_req,
    output logic             sys_reset_out
);
    import wdt_pkg::*;

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        wd_state_t         st;
        logic [CNT_W-1:0]  cnt;
        logic [POST_W-1:0] post;
        logic [HOLD_W-1:0] hold;
        logic [1:0]        sel;
        logic              irq_flag;
        logic              dog_flag;
        logic              rst_en;
        logic              restart;
        logic              tout_ien;
        logic              global_ien;
        logic [1:0]        evt_stat;
        logic [1:0]        evt_mask;
        logic              aw_held;
        logic [7:0]        aw_addr;
        logic              w_held;
        logic [7:0]        w_data;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
    } wd_regs_t;

    wd_regs_t s_ff;
    wd_regs_t nxt_s;

    logic       do_wr;
    logic       wr_lane;
    logic       ta_wr;
    logic       ctrl_wr;
    logic       prot_ok;
    logic       unlock_open;
    logic       tout;
    logic       grace_end;
    logic       hold_end;
    logic [7:0] rd_mux;

    // ********************************************************
    // decode helpers
    // ********************************************************
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == ADDR_CTRL) || (a == ADDR_CLKSEL) || (a == ADDR_TA) ||
                    (a == ADDR_IEN) || (a == ADDR_EVT_STAT) || (a == ADDR_EVT_MASK);
    endfunction

    // last count value of the selected interval
    function automatic logic [CNT_W-1:0] tout_last(input logic [1:0] sel);
        case (sel)
            2'h0:    tout_last = CNT_W'(TOUT0 - 1);
            2'h1:    tout_last = CNT_W'(TOUT1 - 1);
            2'h2:    tout_last = CNT_W'(TOUT2 - 1);
            2'h3:    tout_last = CNT_W'(TOUT3 - 1);
            default: tout_last = CNT_W'(TOUT0 - 1);
        endcase
    endfunction

    // ********************************************************
    // bus handshakes and write strobes
    // ********************************************************
    assign awready = !s_ff.aw_held && !s_ff.bvalid;
    assign wready  = !s_ff.w_held && !s_ff.bvalid;
    assign arready = !s_ff.rvalid;
    assign do_wr   = s_ff.aw_held && s_ff.w_held && !s_ff.bvalid;
    assign wr_lane = do_wr && s_ff.w_lane0;
    assign ta_wr   = wr_lane && (s_ff.aw_addr == ADDR_TA);
    assign ctrl_wr = wr_lane && (s_ff.aw_addr == ADDR_CTRL);
    assign prot_ok = ctrl_wr && unlock_open;

    // ********************************************************
    // watchdog events
    // ********************************************************
    assign tout      = (s_ff.st != ST_DOGRST) && (s_ff.cnt == tout_last(s_ff.sel));
    assign grace_end = (s_ff.st == ST_GRACE) && (s_ff.post == POST_W'(POST_TOUT_CLKS - 1));
    assign hold_end  = (s_ff.st == ST_DOGRST) && (s_ff.hold == HOLD_W'(RST_HOLD_CLKS - 1));

    // read data mux, narrow registers sit in the low byte
    always_comb
    begin
        case (araddr)
            ADDR_CTRL:     rd_mux = {4'h0, s_ff.irq_flag, s_ff.dog_flag, s_ff.rst_en, s_ff.restart};
            ADDR_CLKSEL:   rd_mux = {s_ff.sel, 6'h00};
            ADDR_IEN:      rd_mux = {s_ff.global_ien, 2'h0, s_ff.tout_ien, 4'h0};
            ADDR_EVT_STAT: rd_mux = {6'h00, s_ff.evt_stat};
            ADDR_EVT_MASK: rd_mux = {6'h00, s_ff.evt_mask};
            default:       rd_mux = 8'h00;    // timed access reads as zero
        endcase
    end

    // ********************************************************
    // next state
    // ********************************************************
    always_comb
    begin
        nxt_s = s_ff;

        // write address and data may come in either order
        if (awvalid && awready)
        begin
            nxt_s.aw_held = 1'b1;
            nxt_s.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            nxt_s.w_held  = 1'b1;
            nxt_s.w_data  = wdata[7:0];
            nxt_s.w_lane0 = wstrb[0];
        end
        if (do_wr)
        begin
            nxt_s.aw_held = 1'b0;
            nxt_s.w_held  = 1'b0;
            nxt_s.bvalid  = 1'b1;
            nxt_s.bresp   = is_mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_ff.bvalid && bready)
        begin
            nxt_s.bvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rdata  = rd_mux;
            nxt_s.rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_ff.rvalid && rready)
        begin
            nxt_s.rvalid = 1'b0;
        end

        // software register writes
        if (ctrl_wr && !s_ff.w_data[BIT_DOG_FLAG])
        begin
            nxt_s.dog_flag = 1'b0;
        end
        // protected bits outside the unlock window are silently dropped
        if (prot_ok)
        begin
            nxt_s.rst_en   = s_ff.w_data[BIT_RST_EN];
            nxt_s.irq_flag = s_ff.w_data[BIT_IRQ_FLAG];
            nxt_s.restart  = s_ff.w_data[BIT_RESTART];
        end
        if (wr_lane && s_ff.aw_addr == ADDR_CLKSEL)
        begin
            nxt_s.sel = s_ff.w_data[BIT_SEL_HI:BIT_SEL_LO];
        end
        if (wr_lane && s_ff.aw_addr == ADDR_IEN)
        begin
            nxt_s.tout_ien   = s_ff.w_data[BIT_TOUT_IEN];
            nxt_s.global_ien = s_ff.w_data[BIT_GLOBAL_IEN];
        end
        if (wr_lane && s_ff.aw_addr == ADDR_EVT_STAT)
        begin
            nxt_s.evt_stat = s_ff.evt_stat & ~s_ff.w_data[1:0];
        end
        if (wr_lane && s_ff.aw_addr == ADDR_EVT_MASK)
        begin
            nxt_s.evt_mask = s_ff.w_data[1:0];
        end

        // free-running interval counter, wraps at every timeout
        nxt_s.cnt = tout ? '0 : s_ff.cnt + 1'b1;
        if (tout)
        begin
            // set after the software clear so a coinciding event wins
            nxt_s.irq_flag           = 1'b1;
            nxt_s.evt_stat[EVT_TOUT] = 1'b1;
        end

        case (s_ff.st)
            ST_COUNT:
            begin
                if (tout)
                begin
                    nxt_s.st   = ST_GRACE;
                    nxt_s.post = '0;
                end
            end
            ST_GRACE:
            begin
                nxt_s.post = s_ff.post + 1'b1;
                if (grace_end)
                begin
                    // without reset enable the watchdog is just a timer
                    nxt_s.st = s_ff.rst_en ? ST_DOGRST : ST_COUNT;
                    nxt_s.hold = '0;
                    if (s_ff.rst_en)
                    begin
                        nxt_s.dog_flag             = 1'b1;
                        nxt_s.irq_flag             = 1'b0;
                        nxt_s.evt_stat[EVT_DOGRST] = 1'b1;
                        nxt_s.cnt                  = '0;
                    end
                end
            end
            ST_DOGRST:
            begin
                nxt_s.cnt  = '0;
                nxt_s.hold = s_ff.hold + 1'b1;
                if (hold_end)
                begin
                    nxt_s.st = ST_COUNT;
                end
            end
            default:
            begin
                nxt_s.st = ST_COUNT;
            end
        endcase

        // restart takes effect the cycle after the write, then clears itself
        if (s_ff.restart)
        begin
            nxt_s.restart = 1'b0;
            nxt_s.cnt     = '0;
            nxt_s.post    = '0;
            if (s_ff.st == ST_GRACE)
            begin
                nxt_s.st = ST_COUNT;
            end
        end

        // power fail acts like power-on for the watchdog_control bits and the counters; select, enables and events are kept
        if (power_fail_rst)
        begin
            nxt_s.rst_en   = 1'b0;
            nxt_s.dog_flag = 1'b0;
            nxt_s.irq_flag = 1'b0;
            nxt_s.restart  = 1'b0;
            nxt_s.st       = ST_COUNT;
            nxt_s.cnt      = '0;
            nxt_s.post     = '0;
            nxt_s.hold     = '0;
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_ff     <= '0;
            s_ff.st  <= ST_COUNT;
            s_ff.sel <= SEL_RST;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    ta_unlock u_unlock
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ta_wr       (ta_wr),
        .ta_data     (s_ff.w_data),
        .prot_wr     (prot_ok),
        .unlock_open (unlock_open)
    );

    // ********************************************************
    // outputs
    // ********************************************************
    assign bvalid        = s_ff.bvalid;
    assign bresp         = s_ff.bresp;
    assign rvalid        = s_ff.rvalid;
    assign rdata         = {24'h000000, s_ff.rdata};
    assign rresp         = s_ff.rresp;
    assign sys_reset_out = (s_ff.st == ST_DOGRST);
    assign wdt_irq_req   = s_ff.irq_flag && s_ff.tout_ien && s_ff.global_ien;
    assign irq           = |(s_ff.evt_stat & s_ff.evt_mask);

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence dog_pulse;
        sys_reset_out [*8] ##1 !sys_reset_out;
    endsequence

    sequence grace_expiry;
        grace_end && s_ff.rst_en && !s_ff.restart && !power_fail_rst;
    endsequence

    a_restart_self_clear: assert property (prot_ok && s_ff.w_data[BIT_RESTART] && !power_fail_rst |=> s_ff.restart
        ##1 (!s_ff.restart && s_ff.cnt == 0)) else $error("restart did not clear count or itself");
    a_timeout_sets_flag: assert property (tout && !power_fail_rst |=> s_ff.irq_flag && s_ff.cnt == 0)
        else $error("timeout did not set irq flag");
    a_irq_request: assert property (wdt_irq_req == (s_ff.irq_flag && s_ff.tout_ien && s_ff.global_ien))
        else $error("irq request not tied to flag and enables");
    a_grace_reset: assert property (grace_expiry |=> dog_pulse)
        else $error("watchdog reset missing or wrong length");
    a_reset_length: assert property ($rose(sys_reset_out) |-> dog_pulse)
        else $error("watchdog reset not two machine cycles");
    a_reset_flag: assert property ($rose(sys_reset_out) |-> s_ff.dog_flag && !s_ff.irq_flag && s_ff.rst_en)
        else $error("reset flag not set with watchdog reset");
    a_flag_disabled: assert property (!s_ff.rst_en |=> !$rose(s_ff.dog_flag) && !$rose(sys_reset_out))
        else $error("reset flag moved while reset disabled");
    a_power_fail: assert property (power_fail_rst |=> !s_ff.rst_en && !s_ff.dog_flag && !sys_reset_out)
        else $error("power fail did not disable watchdog");
    a_locked_write: assert property (ctrl_wr && !unlock_open && !s_ff.restart |=> $stable(s_ff.rst_en) &&
        !s_ff.restart) else $error("protected write took effect while locked");
endmodule

/* verif/watchdog_timer_monitor_tb_top.sv */
// self-checking testbench for the watchdog timer monitor
module watchdog_timer_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdt_pkg::*;

    // short intervals keep the run brief; each stays above the 512 clock grace
    localparam int unsigned T0 = 600;
    localparam int unsigned T1 = 700;
    localparam int unsigned T2 = 800;
    localparam int unsigned T3 = 900;

    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        power_fail_rst;
    logic        irq;
    logic        wdt_irq_req;
    logic        sys_reset_out;
    int          bad_count;
    int          samples_checked;
    int          cycles;

    watchdog_timer_monitor #(.TOUT0(T0), .TOUT1(T1), .TOUT2(T2), .TOUT3(T3)) dut_u
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .power_fail_rst(power_fail_rst), .irq(irq), .wdt_irq_req(wdt_irq_req),
        .sys_reset_out(sys_reset_out)
    );

    // ********************************************************
    // clock, hang guard, verdict
    // ********************************************************
    always #4 aclk = ~aclk;

    // the whole sequence needs well under 20000 cycles
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d values, %0d wrong", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic in_range(input int n, input int lo, input int hi, input string what);
        check(32'(n >= lo && n <= hi), 32'h1, what);
    endtask

    // ********************************************************
    // bus master: payload held until its own ready, bready/rready raised with the request and never lowered
    // ********************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        bit done;
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        done = 0;
        while (!done)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                done = 1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
        bit done;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        done = 0;
        while (!done)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata[7:0];
                r = rresp;
                done = 1;
            end
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    task automatic r8(input logic [7:0] a, output logic [7:0] d);
        logic [1:0] r;
        rd(a, d, r);
    endtask

    // unlock pair then the protected write, back to back so it lands inside the window
    task automatic ctrl(input logic [7:0] d);
        w(ADDR_TA, TA_KEY1);
        w(ADDR_TA, TA_KEY2);
        w(ADDR_CTRL, d);
    endtask

    // cycles until irq (sel 0) or sys_reset_out (sel 1) goes high
    task automatic until_high(input bit sel, output int n);
        n = 0;
        while ((sel ? sys_reset_out : irq) !== 1'b1)
        begin
            @(posedge aclk);
            n++;
        end
    endtask

    task automatic no_reset_for(input int len);
        int m;
        m = 0;
        repeat (len)
        begin
            @(posedge aclk);
            m += int'(sys_reset_out === 1'b1);
        end
        check(m, 0, "reset pulse count");
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset_vals();
        logic [7:0] d;
        logic [1:0] r;
        r8(ADDR_CTRL, d);
        check(d, 8'h00, "control after reset");
        r8(ADDR_CLKSEL, d);
        check(d, {SEL_RST, 6'h00}, "select after reset");
        wr(8'h20, 8'h5A, r);
        check(r, RESP_SLVERR, "unmapped write");
        rd(8'h20, d, r);
        check(r, RESP_SLVERR, "unmapped read");
    endtask

    task automatic t_protect();
        logic [7:0] d;
        w(ADDR_CTRL, 8'h02);
        r8(ADDR_CTRL, d);
        check(d[1], 1'b0, "locked write");
        w(ADDR_TA, TA_KEY1);
        w(ADDR_TA, 8'h33);
        w(ADDR_TA, TA_KEY2);
        w(ADDR_CTRL, 8'h02);
        r8(ADDR_CTRL, d);
        check(d[1], 1'b0, "broken key pair");
        w(ADDR_TA, TA_KEY1);
        w(ADDR_TA, TA_KEY2);
        repeat (8) @(posedge aclk);
        w(ADDR_CTRL, 8'h02);
        r8(ADDR_CTRL, d);
        check(d[1], 1'b0, "late write");
        ctrl(8'h02);
        r8(ADDR_CTRL, d);
        check(d[1], 1'b1, "unlocked write");
        ctrl(8'h00);
    endtask

    task automatic t_interval();
        int unsigned tab[4] = '{T0, T1, T2, T3};
        logic [7:0] d;
        int n;
        w(ADDR_EVT_MASK, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            w(ADDR_CLKSEL, 8'(k << 6));
            ctrl(8'h01);
            r8(ADDR_CTRL, d);
            check(d[0], 1'b0, "restart self clear");
            // a mid-count restart must push the time-out a whole interval out
            if (k == 0)
            begin
                repeat (T0 / 2) @(posedge aclk);
                ctrl(8'h01);
            end
            w(ADDR_EVT_STAT, 8'h03);
            until_high(0, n);
            in_range(n, tab[k] - 15, tab[k] + 3, "interval length");
            r8(ADDR_CTRL, d);
            check(d[3], 1'b1, "flag at time-out");
        end
        w(ADDR_CLKSEL, 8'h00);
        ctrl(8'h01);
        w(ADDR_EVT_MASK, 8'h00);
        check(irq, 1'b0, "masked event");
        w(ADDR_EVT_MASK, 8'h01);
        check(irq, 1'b1, "unmasked event");
        w(ADDR_EVT_STAT, 8'h01);
        check(irq, 1'b0, "event cleared");
        r8(ADDR_EVT_STAT, d);
        check(d, 8'h00, "status after clear");
    endtask

    task automatic t_irq_req();
        logic [7:0] en;
        ctrl(8'h09);
        for (int i = 0; i < 4; i++)
        begin
            en = {i[1], 2'b00, i[0], 4'h0};
            w(ADDR_IEN, en);
            check(wdt_irq_req, 1'(i == 3), "irq request gating");
        end
        ctrl(8'h00);
        check(wdt_irq_req, 1'b0, "flag cleared by write");
        w(ADDR_IEN, 8'h00);
    endtask

    task automatic t_dog_reset();
        logic [7:0] d;
        int n;
        int m;
        ctrl(8'h03);
        w(ADDR_EVT_STAT, 8'h03);
        until_high(0, n);
        // restart inside the grace period must hold the reset off
        ctrl(8'h03);
        no_reset_for(POST_TOUT_CLKS + 40);
        w(ADDR_EVT_STAT, 8'h03);
        until_high(0, n);
        until_high(1, n);
        in_range(n, POST_TOUT_CLKS - 6, POST_TOUT_CLKS + 3, "grace length");
        m = 0;
        while (sys_reset_out === 1'b1)
        begin
            @(posedge aclk);
            m++;
        end
        check(m, RST_HOLD_CLKS, "reset width");
        r8(ADDR_CTRL, d);
        check(d, 8'h06, "control after dog reset");
        r8(ADDR_EVT_STAT, d);
        check(d[1], 1'b1, "dog reset event");
        w(ADDR_EVT_STAT, 8'h03);
        until_high(0, n);
        in_range(n, T0 - 25, T0 + 3, "count after dog reset");
        ctrl(8'h04);
        no_reset_for(T0 + 600);
        r8(ADDR_CTRL, d);
        check(d, 8'h0C, "reset disabled, timer runs");
        ctrl(8'h06);
        power_fail_rst <= 1'b1;
        @(posedge aclk);
        power_fail_rst <= 1'b0;
        @(posedge aclk);
        r8(ADDR_CTRL, d);
        check(d, 8'h00, "power fail clears");
        no_reset_for(T0 + 600);
    endtask

    // ********************************************************
    // main sequence
    // ********************************************************
    initial
    begin
        aclk = 0;
        aresetn = 0;
        awaddr = 0;
        awvalid = 0;
        wdata = 0;
        wstrb = 4'hF;
        wvalid = 0;
        bready = 0;
        araddr = 0;
        arvalid = 0;
        rready = 0;
        power_fail_rst = 0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_vals();
        t_protect();
        t_interval();
        t_irq_req();
        t_dog_reset();
        finish_test();
    end
endmodule
